/* File: hdl/emu_mode_defs.svh */
// Offsets, field layout, reset values and timing counts of the execution-mode control
`ifndef EMU_MODE_DEFS_SVH
`define EMU_MODE_DEFS_SVH
`define OFF_SETTINGS   8'h00
`define OFF_COMMAND    8'h04
`define OFF_ENTRY      8'h08
`define OFF_STATUS     8'h0C
`define OFF_RUN_TIME   8'h10
`define OFF_PC_REPORT  8'h14
`define SETTINGS_W     13
`define SETTINGS_RESET 13'h1C16
`define CMD_CANCEL     0
`define CMD_STORE      1
`define CMD_CONFIRM    2
`define CMD_REFUSE     3
`define ENTRY_START    8
`define ENTRY_PERIOD   9
`define ENTRY_EMPTY    10
`define ENTRY_LAST     3'd6
`define CLK_MHZ        250
`define RES1_NS        1600
`define RES2_NS        406
`define RES3_NS        20
`define RES1_CYC       9'(((`RES1_NS * `CLK_MHZ) + 999) / 1000)
`define RES2_CYC       9'(((`RES2_NS * `CLK_MHZ) + 999) / 1000)
`define RES3_CYC       9'(((`RES3_NS * `CLK_MHZ) + 999) / 1000)
`define MON1_MS        200
`define MON2_MS        2000
`define MON_CYC(ms)    ((ms) * `CLK_MHZ * 1000)
`endif

/* File: hdl/emu_mode_pkg.sv */
// Types shared by the execution-mode control
package emu_mode_pkg;
    // Settings word, most significant field first
    typedef struct packed {
        logic       bus_req_en;
        logic [1:0] time_res;
        logic [3:0] trig_sel;
        logic [1:0] mon;
        logic       multi_break;
        logic       reset_en;
        logic [1:0] bus_width;
    } settings_t;
    typedef enum logic [1:0] {ST_LOAD, ST_IDLE, ST_ENTRY} ctl_state_t;
endpackage

/* File: hdl/run_timer.sv */
// Run-time counter ticking at the selected measurement resolution
`timescale 1ns/1ps
`default_nettype none
`include "emu_mode_defs.svh"
module run_timer (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Control
    input  wire logic        run_active,
    input  wire logic [1:0]  time_res,
    // Result
    output logic [31:0]      run_time
);
    logic [8:0]  div_reg, div_next, div_end;
    logic [31:0] time_reg, time_next;
    logic        run_q_reg;

    // Divider restarts with each run so the first unit is whole
    always_comb begin
        case (time_res)
            2'd1:    div_end = `RES1_CYC - 9'd1;
            2'd2:    div_end = `RES2_CYC - 9'd1;
            default: div_end = `RES3_CYC - 9'd1;
        endcase
        div_next  = div_reg;
        time_next = time_reg;
        if (run_active && !run_q_reg) begin
            div_next  = '0;
            time_next = '0;
        end else if (run_active) begin
            div_next = (div_reg >= div_end) ? 9'd0 : div_reg + 9'd1;
            if (div_reg >= div_end) begin
                time_next = time_reg + 32'd1; // [R02]
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg   <= '0;
            time_reg  <= '0;
            run_q_reg <= 1'b0;
        end else begin
            div_reg   <= div_next;
            time_reg  <= time_next;
            run_q_reg <= run_active;
        end
    end
    assign run_time = time_reg;
endmodule
`default_nettype wire

/* File: hdl/trigger_select.sv */
// Group-B match routing to trigger pulse or break request
`timescale 1ns/1ps
`default_nettype none
module trigger_select (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Control
    input  wire logic       run_active,
    input  wire logic [3:0] trig_sel,
    input  wire logic [7:0] group_b_match,
    // Result, combinational from registered history
    output logic            trig_hit,
    output logic            break_hit
);
    logic [7:0] to_trig;
    logic [7:0] match_q_reg;
    logic [7:0] rise;

    // Channel mask: 1..8 one channel, 9 all, 0 none
    for (genvar i = 0; i < 8; i++) begin : g_mask
        assign to_trig[i] = (trig_sel == 4'(i + 1)) || (trig_sel == 4'd9);
    end

    // Only a fresh match counts, so a held condition fires once
    always_comb begin
        rise      = group_b_match & ~match_q_reg;
        trig_hit  = run_active && |(rise & to_trig);  // [R03]
        break_hit = run_active && |(rise & ~to_trig); // [R04]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_q_reg <= '0;
        end else begin
            match_q_reg <= group_b_match;
        end
    end
endmodule
`default_nettype wire

/* File: hdl/emulator_execution_mode_control.sv */
// Execution-mode control: settings, gating, trigger, run timing and storage
// Operation
// R01: Forward bus requests during a run when the bus-request gate is enabled.
// R02: Run time counts at 1.6 us, 406 ns or 20 ns units. The code's middle unit is 102 cycles, which is 408 ns at 250 MHz.
// R03: Trigger pulse on one group-B channel, any channel, or never.
// R04: A group-B condition assigned to trigger pulses and does not halt.
// R05: Trace-stop is unavailable while a trigger output is selected.
// R06: Program counter reported every 200 ms, 2 s, or never.
// R07: Multi-break uses trigger output and probe input to halt together.
// R08: Power-on and manual reset inputs pass only when the reset gate is enabled.
// R09: Emulation memory bus is 32-bit for code 1, 16-bit for code 2.
// R10: Cancel during a run leaves parallel mode.
// R11: Cancel discards trace records and restarts capture from empty.
// R12: Confirmed store writes settings to nonvolatile memory; refusal keeps it.
// R13: In item entry, empty keeps the item; period ends, keeping changes.
// R14: Gate, trigger and width settings latch before the next run starts.
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "emu_mode_defs.svh"
module emulator_execution_mode_control #(
    parameter int unsigned MON1_CYCLES = `MON_CYC(`MON1_MS),
    parameter int unsigned MON2_CYCLES = `MON_CYC(`MON2_MS)
) (
    // APB
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    // Target side
    input  wire logic                   run_active,
    input  wire logic [31:0]            pc_in,
    input  wire logic                   bus_request_input,
    input  wire logic                   power_on_reset_input,
    input  wire logic                   manual_reset_input,
    input  wire logic [7:0]             group_b_match,
    input  wire logic                   probe_break_in,
    output logic                        bus_request_out,
    output logic                        power_on_reset_out,
    output logic                        manual_reset_out,
    output logic                        emu_mem_bus_32,
    output logic                        trigger_out,
    output logic                        break_request,
    output logic                        trace_stop_allowed,
    output logic                        trace_restart,
    output logic                        status_report,
    // Nonvolatile configuration
    input  wire emu_mode_pkg::settings_t nv_cfg_in,
    input  wire logic                   nv_valid,
    output emu_mode_pkg::settings_t     nv_cfg_out,
    output logic                        nv_write
);
    import emu_mode_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    settings_t   set_reg, set_next, act_reg, act_next, nv_data_reg, nv_data_next;
    ctl_state_t  state_reg, state_next;
    logic [2:0]  item_reg, item_next;
    logic        par_reg, par_next, pend_reg, pend_next, nvw_reg, nvw_next;
    logic        restart_reg, restart_next, run_q_reg;
    logic [31:0] prdata_reg, prdata_next, pc_rep_reg, pc_rep_next, mon_cnt_reg, mon_cnt_next;
    logic        pready_reg, pready_next, pslverr_reg, pslverr_next, rep_reg, rep_next;
    logic        bus_request_input_reg, por_reg, mrs_reg, bw32_reg, trig_reg, brk_reg, tsa_reg;
    logic        wr_fire, rd_fire, mapped, trig_hit, break_hit;
    logic [31:0] run_time, mon_end;

    // Keep a field only when its code is legal
    function automatic settings_t legalize(input settings_t old_v, input settings_t new_v);
        settings_t r;
        r = new_v;
        if (new_v.time_res == 2'd0) r.time_res = old_v.time_res;
        if (new_v.trig_sel > 4'd9) r.trig_sel = old_v.trig_sel;
        if (new_v.mon == 2'd3) r.mon = old_v.mon;
        if (new_v.bus_width == 2'd0 || new_v.bus_width == 2'd3) r.bus_width = old_v.bus_width;
        return r;
    endfunction

    // Apply one interactive item; value in the low nibble
    function automatic settings_t apply_item(input settings_t s, input logic [2:0] idx, input logic [3:0] v);
        settings_t r;
        r = s;
        case (idx)
            3'd0:    r.bus_req_en  = v[0];
            3'd1:    r.time_res    = v[1:0];
            3'd2:    r.trig_sel    = v;
            3'd3:    r.mon         = v[1:0];
            3'd4:    r.multi_break = v[0];
            3'd5:    r.reset_en    = v[0];
            default: r.bus_width   = v[1:0];
        endcase
        return legalize(s, r);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Submodules
    run_timer u_run_timer (
        .pclk       (pclk),
        .presetn    (presetn),
        .run_active (run_active),
        .time_res   (act_reg.time_res),
        .run_time   (run_time)
    );

    trigger_select u_trigger_select (
        .pclk          (pclk),
        .presetn       (presetn),
        .run_active    (run_active),
        .trig_sel      (act_reg.trig_sel),
        .group_b_match (group_b_match),
        .trig_hit      (trig_hit),
        .break_hit     (break_hit)
    );

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, then the access completes
    assign wr_fire = psel && penable && pready_reg && pwrite;
    assign rd_fire = psel && penable && !pready_reg && !pwrite;

    always_comb begin
        if (paddr == `OFF_SETTINGS) mapped = 1'b1;
        else if (paddr == `OFF_COMMAND) mapped = 1'b1;
        else if (paddr == `OFF_ENTRY) mapped = 1'b1;
        else if (paddr == `OFF_STATUS) mapped = 1'b1;
        else if (paddr == `OFF_RUN_TIME) mapped = 1'b1;
        else if (paddr == `OFF_PC_REPORT) mapped = 1'b1;
        else mapped = 1'b0;
        pready_next  = psel && penable && !pready_reg;
        pslverr_next = psel && penable && !pready_reg && !mapped;
        prdata_next  = '0;
        if (rd_fire) begin
            if (paddr == `OFF_SETTINGS) prdata_next = 32'(set_reg);
            else if (paddr == `OFF_STATUS) begin
                prdata_next = {25'h000_0000, pend_reg, item_reg, state_reg == ST_ENTRY, par_reg, run_active};
            end else if (paddr == `OFF_RUN_TIME) prdata_next = run_time;
            else if (paddr == `OFF_PC_REPORT) prdata_next = pc_rep_reg;
            else prdata_next = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Settings, entry sequence and storage
    always_comb begin
        state_next   = state_reg;
        set_next     = set_reg;
        item_next    = item_reg;
        pend_next    = pend_reg;
        nvw_next     = 1'b0;
        nv_data_next = nv_data_reg;
        case (state_reg)
            ST_LOAD: begin
                // Stored configuration applies at activation
                set_next   = nv_valid ? legalize(settings_t'(`SETTINGS_RESET), nv_cfg_in) : set_reg; // [R12]
                state_next = ST_IDLE;
            end
            ST_IDLE: begin
                if (wr_fire && paddr == `OFF_SETTINGS) begin
                    set_next = legalize(set_reg, settings_t'(pwdata[`SETTINGS_W-1:0]));
                end else if (wr_fire && paddr == `OFF_ENTRY && pwdata[`ENTRY_START]) begin
                    state_next = ST_ENTRY;
                    item_next  = '0;
                end
            end
            default: begin
                if (wr_fire && paddr == `OFF_ENTRY) begin
                    if (pwdata[`ENTRY_PERIOD]) begin
                        state_next = ST_IDLE; // [R13]
                    end else begin
                        if (!pwdata[`ENTRY_EMPTY]) begin
                            set_next = apply_item(set_reg, item_reg, pwdata[3:0]); // [R13]
                        end
                        item_next  = item_reg + 3'd1;
                        state_next = (item_reg == `ENTRY_LAST) ? ST_IDLE : ST_ENTRY;
                    end
                end
            end
        endcase
        // Store needs a request then a yes; a no drops it
        if (wr_fire && paddr == `OFF_COMMAND) begin
            if (pwdata[`CMD_STORE]) begin
                pend_next = 1'b1;
            end else if (pend_reg && pwdata[`CMD_CONFIRM]) begin
                pend_next    = 1'b0;
                nvw_next     = 1'b1; // [R12]
                nv_data_next = set_reg;
            end else if (pwdata[`CMD_REFUSE]) begin
                pend_next = 1'b0; // [R12]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Run-side state: latched settings, parallel mode, status reports
    always_comb begin
        // Settings only move between runs so a run sees one consistent set
        act_next     = run_active ? act_reg : set_reg; // [R14]
        par_next     = par_reg;
        restart_next = 1'b0;
        if (run_active && !run_q_reg) begin
            par_next = 1'b1;
        end else if (!run_active) begin
            par_next = 1'b0;
        end
        if (wr_fire && paddr == `OFF_COMMAND && pwdata[`CMD_CANCEL] && run_active && par_reg) begin
            par_next     = 1'b0; // [R10]
            restart_next = 1'b1; // [R11]
        end
        mon_end      = (act_reg.mon == 2'd2) ? MON2_CYCLES - 32'd1 : MON1_CYCLES - 32'd1;
        mon_cnt_next = '0;
        rep_next     = 1'b0;
        pc_rep_next  = pc_rep_reg;
        if (run_active && act_reg.mon != 2'd0) begin
            mon_cnt_next = (mon_cnt_reg >= mon_end) ? 32'd0 : mon_cnt_reg + 32'd1;
            if (mon_cnt_reg >= mon_end) begin
                rep_next    = 1'b1; // [R06]
                pc_rep_next = pc_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg   <= ST_LOAD;
            set_reg     <= settings_t'(`SETTINGS_RESET);
            act_reg     <= settings_t'(`SETTINGS_RESET);
            nv_data_reg <= settings_t'(`SETTINGS_RESET);
            item_reg    <= '0;
            pend_reg    <= 1'b0;
            nvw_reg     <= 1'b0;
            par_reg     <= 1'b0;
            restart_reg <= 1'b0;
            run_q_reg   <= 1'b0;
            mon_cnt_reg <= '0;
            rep_reg     <= 1'b0;
            pc_rep_reg  <= '0;
            prdata_reg  <= '0;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            bus_request_input_reg    <= 1'b0;
            por_reg     <= 1'b0;
            mrs_reg     <= 1'b0;
            bw32_reg    <= 1'b0;
            trig_reg    <= 1'b0;
            brk_reg     <= 1'b0;
            tsa_reg     <= 1'b1;
        end else begin
            state_reg   <= state_next;
            set_reg     <= set_next;
            act_reg     <= act_next;
            nv_data_reg <= nv_data_next;
            item_reg    <= item_next;
            pend_reg    <= pend_next;
            nvw_reg     <= nvw_next;
            par_reg     <= par_next;
            restart_reg <= restart_next;
            run_q_reg   <= run_active;
            mon_cnt_reg <= mon_cnt_next;
            rep_reg     <= rep_next;
            pc_rep_reg  <= pc_rep_next;
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
            bus_request_input_reg    <= run_active && act_reg.bus_req_en && bus_request_input; // [R01]
            por_reg     <= act_reg.reset_en && power_on_reset_input;              // [R08]
            mrs_reg     <= act_reg.reset_en && manual_reset_input;                // [R08]
            bw32_reg    <= act_reg.bus_width == 2'd1;                             // [R09]
            trig_reg    <= trig_hit;                                              // [R03]
            // Probe input halts this unit too when units break together
            brk_reg     <= break_hit || (run_active && act_reg.multi_break && probe_break_in); // [R07]
            tsa_reg     <= act_reg.trig_sel == 4'd0;                              // [R05]
        end
    end

    assign prdata             = prdata_reg;
    assign pready             = pready_reg;
    assign pslverr            = pslverr_reg;
    assign bus_request_out    = bus_request_input_reg;
    assign power_on_reset_out = por_reg;
    assign manual_reset_out   = mrs_reg;
    assign emu_mem_bus_32     = bw32_reg;
    assign trigger_out        = trig_reg;
    assign break_request      = brk_reg;
    assign trace_stop_allowed = tsa_reg;
    assign trace_restart      = restart_reg;
    assign status_report      = rep_reg;
    assign nv_cfg_out         = nv_data_reg;
    assign nv_write           = nvw_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_bus_request_input_gate;
        @(posedge pclk) disable iff (!presetn)
        (!run_active || !act_reg.bus_req_en) |=> !bus_request_out;
    endproperty
    a_bus_request_input_gate: assert property (p_bus_request_input_gate) else $error("bus request passed while gated"); // [R01]
    property p_trig_never;
        @(posedge pclk) disable iff (!presetn)
        (act_reg.trig_sel == 4'd0) |=> !trigger_out;
    endproperty
    a_trig_never: assert property (p_trig_never) else $error("trigger pulse with trigger off"); // [R03]
    property p_trig_no_halt;
        @(posedge pclk) disable iff (!presetn)
        (act_reg.trig_sel == 4'd9 && !(act_reg.multi_break && probe_break_in)) |=> !break_request;
    endproperty
    a_trig_no_halt: assert property (p_trig_no_halt) else $error("halt on trigger condition"); // [R04]
    property p_trace_stop;
        @(posedge pclk) disable iff (!presetn)
        (act_reg.trig_sel != 4'd0) |=> !trace_stop_allowed;
    endproperty
    a_trace_stop: assert property (p_trace_stop) else $error("trace stop offered with trigger"); // [R05]
    property p_mon_off;
        @(posedge pclk) disable iff (!presetn)
        (act_reg.mon == 2'd0) |=> !status_report;
    endproperty
    a_mon_off: assert property (p_mon_off) else $error("status report while disabled"); // [R06]
    property p_multi_break;
        @(posedge pclk) disable iff (!presetn)
        (run_active && act_reg.multi_break && probe_break_in) |=> break_request;
    endproperty
    a_multi_break: assert property (p_multi_break) else $error("probe did not halt"); // [R07]
    property p_reset_gate;
        @(posedge pclk) disable iff (!presetn)
        !act_reg.reset_en |=> !power_on_reset_out && !manual_reset_out;
    endproperty
    a_reset_gate: assert property (p_reset_gate) else $error("reset passed while gated"); // [R08]
    property p_width;
        @(posedge pclk) disable iff (!presetn)
        ##1 emu_mem_bus_32 == ($past(act_reg.bus_width) == 2'd1);
    endproperty
    a_width: assert property (p_width) else $error("bus width mismatch"); // [R09]
    property p_cancel;
        @(posedge pclk) disable iff (!presetn)
        trace_restart |-> !par_reg ##1 !trace_restart;
    endproperty
    a_cancel: assert property (p_cancel) else $error("parallel mode kept after cancel"); // [R10]
    property p_refuse;
        @(posedge pclk) disable iff (!presetn)
        !pend_reg |=> !nv_write;
    endproperty
    a_refuse: assert property (p_refuse) else $error("store without confirmation"); // [R12]
    property p_latch;
        @(posedge pclk) disable iff (!presetn)
        run_active && $past(run_active) |-> $stable(act_reg);
    endproperty
    a_latch: assert property (p_latch) else $error("settings changed mid-run"); // [R14]
    c_trigger: cover property (@(posedge pclk) disable iff (!presetn) trigger_out);
    c_cancel: cover property (@(posedge pclk) disable iff (!presetn) trace_restart);
    c_store: cover property (@(posedge pclk) disable iff (!presetn) nv_write);
    c_entry: cover property (@(posedge pclk) disable iff (!presetn) state_reg == ST_ENTRY ##1 state_reg == ST_IDLE);
endmodule
`default_nettype wire

/* File: verification/target_model.sv */
// Stand-in for the target microcontroller: run flag, program counter and request lines
`timescale 1ns/1ps
`default_nettype none
module target_model (
    // Clock and scenario control from the bench
    input  wire logic        pclk,
    input  wire logic [12:0] ctl,
    // Target outputs
    output logic             run_active,
    output logic [31:0]      pc_in,
    output logic [7:0]       group_b_match,
    output logic [3:0]       req_lines
);
    // Lines move just after the edge, as a synchronous target would
    always @(posedge pclk) begin
        run_active <= ctl[12];
        group_b_match <= ctl[11:4];
        req_lines <= ctl[3:0]; // bit 3 is the multi-break probe
        pc_in <= run_active ? pc_in + 32'h0000_0002 : 32'h0000_1000;
    end
endmodule
`default_nettype wire

/* File: verification/emulator_execution_mode_control_tb.sv */
// Self-checking bench for the execution-mode control
`timescale 1ns/1ps
`default_nettype none
module emulator_execution_mode_control_tb;
    import emu_mode_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, nv_write, run_active;
    logic        bus_request_out, power_on_reset_out, manual_reset_out, emu_mem_bus_32;
    logic        trigger_out, break_request, trace_stop_allowed, trace_restart, status_report;
    logic [7:0]  paddr, group_b_match;
    logic [31:0] pwdata, prdata, pc_in;
    logic [3:0]  req_lines;
    logic [12:0] ctl;
    settings_t   nv_cfg_out;
    logic [32:0] expq[$];
    int          n_fail, checked, n_trg, n_brk, n_rst, n_nv, n_rep;

    ////////////////////////////////////////////////////////////////////////
    // Short status intervals keep the run brief
    emulator_execution_mode_control #(.MON1_CYCLES(5), .MON2_CYCLES(50)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .run_active(run_active), .pc_in(pc_in), .bus_request_input(req_lines[0]),
        .power_on_reset_input(req_lines[1]), .manual_reset_input(req_lines[2]),
        .group_b_match(group_b_match), .probe_break_in(req_lines[3]),
        .bus_request_out(bus_request_out), .power_on_reset_out(power_on_reset_out),
        .manual_reset_out(manual_reset_out), .emu_mem_bus_32(emu_mem_bus_32),
        .trigger_out(trigger_out), .break_request(break_request),
        .trace_stop_allowed(trace_stop_allowed), .trace_restart(trace_restart),
        .status_report(status_report), .nv_cfg_in(settings_t'(13'h0000)), .nv_valid(1'b0),
        .nv_cfg_out(nv_cfg_out), .nv_write(nv_write));
    target_model model_u (.pclk(pclk), .ctl(ctl), .run_active(run_active), .pc_in(pc_in),
        .group_b_match(group_b_match), .req_lines(req_lines));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; the expected answer goes on the queue for the monitor
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        expq.push_back({e, (w | e) ? 32'h0000_0000 : d});
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) n_fail++;
        // Idle edge so the next setup never lands in the same time step
        @(posedge pclk);
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Monitor: pulse counters and the answer of every completed transfer
    always @(posedge pclk) begin
        n_trg += trigger_out;
        n_brk += break_request;
        n_rst += trace_restart;
        n_nv += nv_write;
        n_rep += status_report;
        if (psel && penable && pready === 1'b1) chk({pslverr, pwrite ? 32'h0 : prdata}, expq.pop_front());
    end

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // Watchdog, far beyond the hundred or so cycles the tests need
    initial begin
        #200us;
        n_fail++;
        end_of_test();
    end

    initial begin
        logic [3:0]  ch;
        logic [12:0] sv;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        ctl = 13'h0000;
        void'($urandom(32'hc6203ad5));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 8'h00, 32'h0000_1C16, 1'b0); // shipment defaults
        apb(1'b0, 8'h20, 32'h0000_0000, 1'b1); // unmapped place refused
        // Item entry: skip gate, set time code 1, then stop with a period
        apb(1'b1, 8'h08, 32'h0000_0100, 1'b0);
        apb(1'b1, 8'h08, 32'h0000_0400, 1'b0);
        apb(1'b1, 8'h08, 32'h0000_0001, 1'b0);
        apb(1'b1, 8'h08, 32'h0000_0200, 1'b0);
        apb(1'b0, 8'h00, 32'h0000_1416, 1'b0);
        // Both gates shut, 32-bit width, target asserting bus request and both reset lines in a run
        apb(1'b1, 8'h00, 32'h0000_0C11, 1'b0);
        ctl <= 13'h1007;
        repeat (4) @(posedge pclk);
        chk({bus_request_out, power_on_reset_out, manual_reset_out, emu_mem_bus_32}, 4'b0001);
        ctl <= 13'h0000;
        // Random trigger channel or any (9), gates open, multi-break on, 16-bit width
        ch = 4'($urandom_range(9, 1));
        sv = 13'h1C1E | (13'(ch) << 6);
        apb(1'b1, 8'h00, {19'h0, sv}, 1'b0);
        ctl <= 13'h1007;
        repeat (4) @(posedge pclk);
        chk(trace_stop_allowed, 1'b0);
        chk({bus_request_out, power_on_reset_out, manual_reset_out, emu_mem_bus_32}, 4'b1110);
        n_trg <= 0;
        n_brk <= 0;
        ctl <= {1'b1, 8'(1 << ((ch - 1) % 8)), 4'h7};
        repeat (6) @(posedge pclk);
        chk(n_trg, 1);
        chk(n_brk, 0);
        n_rst <= 0;
        apb(1'b1, 8'h04, 32'h0000_0001, 1'b0);
        repeat (2) @(posedge pclk);
        chk(n_rst, 1);
        // Probe alone halts this unit while multi-break is on
        ctl <= 13'h1008;
        @(posedge pclk);
        ctl <= 13'h0000;
        repeat (3) @(posedge pclk);
        chk(n_brk, 1);
        // Cancel outside a run must do nothing
        apb(1'b1, 8'h04, 32'h0000_0001, 1'b0);
        repeat (2) @(posedge pclk);
        chk(n_rst, 1);
        // Store confirmed, then store refused
        n_nv <= 0;
        apb(1'b1, 8'h04, 32'h0000_0002, 1'b0);
        apb(1'b1, 8'h04, 32'h0000_0004, 1'b0);
        repeat (2) @(posedge pclk);
        chk(n_nv, 1);
        chk(nv_cfg_out, sv);
        apb(1'b1, 8'h04, 32'h0000_0002, 1'b0);
        apb(1'b1, 8'h04, 32'h0000_0008, 1'b0);
        // A yes after the no must find nothing pending
        apb(1'b1, 8'h04, 32'h0000_0004, 1'b0);
        repeat (2) @(posedge pclk);
        chk(n_nv, 1);
        chk(n_rep, 3);
        apb(1'b0, 8'h10, 32'h0000_0003, 1'b0); // three 20 ns units in the second run
        end_of_test();
    end
endmodule
`default_nettype wire
